//--- inc/rail_seq_pkg.sv
// Package with timing constants, sequence options and states for the three-rail sequencer
package rail_seq_pkg;
   // ---------------------------------------------------------------
   // Clock and timebase
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned TICK_US        = 100;
   localparam int unsigned TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned TICKS_PER_MS   = 1000 / TICK_US;
   // ---------------------------------------------------------------
   // Delays in their own units
   // ---------------------------------------------------------------
   localparam int unsigned DEFAULT_DELAY_MS = 10;
   localparam int unsigned DEFAULT_DELAY_TICKS = DEFAULT_DELAY_MS * TICKS_PER_MS;
   localparam int unsigned REFRESH_US     = 400;
   localparam int unsigned REFRESH_TICKS  = (REFRESH_US + TICK_US - 1) / TICK_US;
   localparam int unsigned SETTLE_MS      = 120;
   localparam int unsigned SETTLE_TICKS   = SETTLE_MS * TICKS_PER_MS;
   localparam int unsigned TIMER_W        = 16;
   // ---------------------------------------------------------------
   // Power-down order options
   // ---------------------------------------------------------------
   localparam logic [2:0] SEQ_321 = 3'h0;
   localparam logic [2:0] SEQ_312 = 3'h1;
   localparam logic [2:0] SEQ_231 = 3'h2;
   localparam logic [2:0] SEQ_213 = 3'h3;
   localparam logic [2:0] SEQ_132 = 3'h4;
   localparam logic [2:0] SEQ_123 = 3'h5;
   localparam logic [2:0] SEQ_DEFAULT = SEQ_321;
   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF,
      ST_UP,
      ST_ON,
      ST_DOWN,
      ST_SETTLE_UP,
      ST_SETTLE_DOWN
   } seq_state_t;
endpackage

//--- rtl/tick_divider.sv
// Master timebase divider producing a one-cycle tick enable
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
   parameter int unsigned DIVIDE = rail_seq_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Tick output
   output logic      tick
);
   localparam int unsigned CW = $clog2(DIVIDE) + 1;
   logic [CW-1:0] count;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (count == CW'(DIVIDE - 1)) begin
         count <= '0;
         tick  <= 1'b1;
      end else begin
         count <= count + CW'(1);
         tick  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- rtl/three_rail_sequencer.sv
// Three-rail power sequencer: enable-driven open-drain release and pull-down of three flags
// ---------------------------------------------------------------
// Overview of operation
// - Six timers: three power-up, three power-down
// - Flags low after reset until enable
// - Enable: timer then release flags 1,2,3
// - Disable: timer then pull flags down sequentially
// - Power-down delays independent from power-up delays
// - Enable drop during first timer cancels
// - Late drop finishes power-up, then power-down
// - Wait 120 ms after interrupted power-up
// - Late rise finishes power-down, then power-up
// - Wait 120 ms after interrupted power-down
// - All timers from one master tick
// - Add 400 us to timers one, four
// - Default order up 1-2-3, down 3-2-1
// - Power-up fixed, power-down follows option
// - Flags open-drain: pull low or release
// - Six selectable power-down orders
// - Standard options: one common delay value
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module three_rail_sequencer #(
   // Standard builds give all six delays the same common value
   parameter int unsigned DELAY1_TICKS = rail_seq_pkg::DEFAULT_DELAY_TICKS,
   parameter int unsigned DELAY2_TICKS = rail_seq_pkg::DEFAULT_DELAY_TICKS,
   parameter int unsigned DELAY3_TICKS = rail_seq_pkg::DEFAULT_DELAY_TICKS,
   parameter int unsigned DELAY4_TICKS = rail_seq_pkg::DEFAULT_DELAY_TICKS,
   parameter int unsigned DELAY5_TICKS = rail_seq_pkg::DEFAULT_DELAY_TICKS,
   parameter int unsigned DELAY6_TICKS = rail_seq_pkg::DEFAULT_DELAY_TICKS,
   parameter logic [2:0]  DOWN_ORDER   = rail_seq_pkg::SEQ_DEFAULT,
   parameter int unsigned TICK_DIVIDE  = rail_seq_pkg::TICK_CYCLES,
   parameter int unsigned SETTLE_TICKS = rail_seq_pkg::SETTLE_TICKS
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Enable pin, asynchronous to clk
   input  wire logic enable,
   // Open-drain flags: input level, output level, output enable
   input  wire logic rail_release_first_in,
   output logic      rail_release_first_out,
   output logic      rail_release_first_oe,
   input  wire logic rail_release_second_in,
   output logic      rail_release_second_out,
   output logic      rail_release_second_oe,
   input  wire logic rail_release_third_in,
   output logic      rail_release_third_out,
   output logic      rail_release_third_oe,
   // Status
   output logic      sequence_busy
);
   localparam int unsigned TW = rail_seq_pkg::TIMER_W;

   // ---------------------------------------------------------------
   // Enable synchroniser
   // ---------------------------------------------------------------
   logic [2:0] en_sync;
   logic       en_level;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         en_sync <= 3'h0;
      end else begin
         en_sync <= {en_sync[1:0], enable};
      end
   end

   // A change counts once the second and third stages agree
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         en_level <= 1'b0;
      end else if (en_sync[1] == en_sync[2]) begin
         en_level <= en_sync[2];
      end
   end

   // ---------------------------------------------------------------
   // Master timebase
   // ---------------------------------------------------------------
   logic tick;

   tick_divider #(
      .DIVIDE (TICK_DIVIDE)
   ) u_tick (
      .clk   (clk),
      .reset (reset),
      .tick  (tick)
   );

   // ---------------------------------------------------------------
   // Delay table
   // ---------------------------------------------------------------
   // Six independent delays; the first of each direction carries the refresh overhead
   function automatic logic [TW-1:0] delay_of(input logic down, input logic [1:0] step);
      int unsigned d;
      d = 0;
      if (!down) begin
         unique case (step)
            2'd0:    d = DELAY1_TICKS + rail_seq_pkg::REFRESH_TICKS;
            2'd1:    d = DELAY2_TICKS;
            default: d = DELAY3_TICKS;
         endcase
      end else begin
         unique case (step)
            2'd0:    d = DELAY4_TICKS + rail_seq_pkg::REFRESH_TICKS;
            2'd1:    d = DELAY5_TICKS;
            default: d = DELAY6_TICKS;
         endcase
      end
      if (d == 0) begin
         d = 1;
      end
      return d[TW-1:0];
   endfunction

   // Flag index pulled low at each power-down step
   function automatic logic [1:0] down_flag(input logic [1:0] step);
      logic [5:0] ord;
      ord = 6'h00;
      unique case (DOWN_ORDER)
         rail_seq_pkg::SEQ_321: ord = {2'd0, 2'd1, 2'd2};
         rail_seq_pkg::SEQ_312: ord = {2'd1, 2'd0, 2'd2};
         rail_seq_pkg::SEQ_231: ord = {2'd0, 2'd2, 2'd1};
         rail_seq_pkg::SEQ_213: ord = {2'd2, 2'd0, 2'd1};
         rail_seq_pkg::SEQ_132: ord = {2'd1, 2'd2, 2'd0};
         default:               ord = {2'd2, 2'd1, 2'd0};
      endcase
      unique case (step)
         2'd0:    return ord[1:0];
         2'd1:    return ord[3:2];
         default: return ord[5:4];
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Sequencer state
   // ---------------------------------------------------------------
   rail_seq_pkg::seq_state_t state;
   logic [1:0]    step;
   logic [TW-1:0] timer;
   logic [2:0]    released;
   logic          pending;
   logic          expired;

   assign expired = tick && (timer == TW'(1));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state    <= rail_seq_pkg::ST_OFF;
         step     <= 2'd0;
         timer    <= '0;
         released <= 3'h0;
         pending  <= 1'b0;
      end else begin
         unique case (state)
            rail_seq_pkg::ST_OFF: begin
               if (en_level) begin
                  state <= rail_seq_pkg::ST_UP;
                  step  <= 2'd0;
                  timer <= delay_of(1'b0, 2'd0);
                  pending <= 1'b0;
               end
            end
            rail_seq_pkg::ST_UP: begin
               if (!en_level && step == 2'd0) begin
                  state <= rail_seq_pkg::ST_OFF;
               end else if (!en_level && !pending) begin
                  // Late drop restarts the running timer and completes power-up
                  pending <= 1'b1;
                  timer   <= delay_of(1'b0, step);
               end else if (expired) begin
                  released[step] <= 1'b1;
                  if (step == 2'd2) begin
                     if (pending) begin
                        state <= rail_seq_pkg::ST_SETTLE_DOWN;
                        timer <= TW'(SETTLE_TICKS);
                     end else begin
                        state <= rail_seq_pkg::ST_ON;
                     end
                  end else begin
                     step  <= step + 2'd1;
                     timer <= delay_of(1'b0, step + 2'd1);
                  end
               end else if (tick) begin
                  timer <= timer - TW'(1);
               end
            end
            rail_seq_pkg::ST_ON: begin
               if (!en_level) begin
                  state   <= rail_seq_pkg::ST_DOWN;
                  step    <= 2'd0;
                  timer   <= delay_of(1'b1, 2'd0);
                  pending <= 1'b0;
               end
            end
            rail_seq_pkg::ST_DOWN: begin
               if (en_level && step == 2'd0) begin
                  state <= rail_seq_pkg::ST_ON;
               end else if (en_level && !pending) begin
                  pending <= 1'b1;
                  timer   <= delay_of(1'b1, step);
               end else if (expired) begin
                  released[down_flag(step)] <= 1'b0;
                  if (step == 2'd2) begin
                     if (pending) begin
                        state <= rail_seq_pkg::ST_SETTLE_UP;
                        timer <= TW'(SETTLE_TICKS);
                     end else begin
                        state <= rail_seq_pkg::ST_OFF;
                     end
                  end else begin
                     step  <= step + 2'd1;
                     timer <= delay_of(1'b1, step + 2'd1);
                  end
               end else if (tick) begin
                  timer <= timer - TW'(1);
               end
            end
            rail_seq_pkg::ST_SETTLE_DOWN: begin
               // After the wait, follow the enable level as it stands then
               if (expired) begin
                  pending <= 1'b0;
                  step    <= 2'd0;
                  if (en_level) begin
                     state <= rail_seq_pkg::ST_ON;
                  end else begin
                     state <= rail_seq_pkg::ST_DOWN;
                     timer <= delay_of(1'b1, 2'd0);
                  end
               end else if (tick) begin
                  timer <= timer - TW'(1);
               end
            end
            rail_seq_pkg::ST_SETTLE_UP: begin
               if (expired) begin
                  pending <= 1'b0;
                  step    <= 2'd0;
                  if (en_level) begin
                     state <= rail_seq_pkg::ST_UP;
                     timer <= delay_of(1'b0, 2'd0);
                  end else begin
                     state <= rail_seq_pkg::ST_OFF;
                  end
               end else if (tick) begin
                  timer <= timer - TW'(1);
               end
            end
            default: begin
               state <= rail_seq_pkg::ST_OFF;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Open-drain outputs
   // ---------------------------------------------------------------
   // Output level is always low; the pad is released by dropping the enable
   assign rail_release_first_out  = 1'b0;
   assign rail_release_second_out = 1'b0;
   assign rail_release_third_out  = 1'b0;
   assign rail_release_first_oe   = ~released[0];
   assign rail_release_second_oe  = ~released[1];
   assign rail_release_third_oe   = ~released[2];

   assign sequence_busy = (state != rail_seq_pkg::ST_OFF) && (state != rail_seq_pkg::ST_ON);
endmodule
`default_nettype wire

//--- dv/rail_seq_chk.sv
// Port-level assertions for the three-rail sequencer
`timescale 1ns/1ps
`default_nettype none
module rail_seq_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Flags and status
   input wire logic rail_release_first_out,
   input wire logic rail_release_second_out,
   input wire logic rail_release_third_out,
   input wire logic rail_release_first_oe,
   input wire logic rail_release_second_oe,
   input wire logic rail_release_third_oe,
   input wire logic sequence_busy
);
   wire logic [2:0] oe   = {rail_release_third_oe, rail_release_second_oe, rail_release_first_oe};
   wire logic [2:0] outs = {rail_release_third_out, rail_release_second_out, rail_release_first_out};
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_reset_low;
      disable iff (1'b0) reset |-> oe == 3'h7;
   endproperty
   property p_out_zero;
      outs == 3'h0;
   endproperty
   property p_up_second;
      $fell(oe[1]) |-> !oe[0];
   endproperty
   property p_up_third;
      $fell(oe[2]) |-> oe[1:0] == 2'h0;
   endproperty
   property p_down_second;
      $rose(oe[1]) |-> oe[2];
   endproperty
   property p_down_first;
      $rose(oe[0]) |-> oe[2:1] == 2'h3;
   endproperty
   property p_idle_equal;
      !sequence_busy |-> oe == 3'h0 || oe == 3'h7;
   endproperty
   property p_change_busy;
      !$stable(oe) |-> $past(sequence_busy);
   endproperty
   a_reset_low: assert property (p_reset_low) else $error("flags not low in reset");
   a_out_zero: assert property (p_out_zero) else $error("flag drives high");
   a_up_second: assert property (p_up_second) else $error("second released early");
   a_up_third: assert property (p_up_third) else $error("third released early");
   a_down_second: assert property (p_down_second) else $error("second pulled early");
   a_down_first: assert property (p_down_first) else $error("first pulled early");
   a_idle_equal: assert property (p_idle_equal) else $error("idle with mixed flags");
   a_change_busy: assert property (p_change_busy) else $error("flag moved while idle");
   c_full_up: cover property ($fell(oe[2]));
   c_full_down: cover property ($rose(oe[0]));
   c_cancel: cover property ($fell(sequence_busy) && oe == 3'h0);
endmodule
`default_nettype wire

//--- dv/flag_pullups.sv
// Pull-up model of the regulator enable inputs on the flags
`timescale 1ns/1ps
`default_nettype none
module flag_pullups (
   // Flag drive from the sequencer
   input  wire logic [2:0] oe,
   input  wire logic [2:0] outs,
   // Resolved pad levels
   output logic      [2:0] level
);
   // Pulled low only while driven, otherwise the pull-up wins
   assign level = (oe & outs) | ~oe;
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the three-rail sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int TD = 2;
   localparam int D1 = 3, D2 = 4, D3 = 5, D4 = 6, D5 = 7, D6 = 8, SET = 5;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic       enable = 1'b0;
   logic       busy;
   logic [2:0] oe;
   logic [2:0] outs;
   wire  [2:0] lvl;
   int         mismatches = 0;
   int         compares = 0;
   int         cyc = 0;
   int         n;
   always #50 clk = ~clk;
   three_rail_sequencer #(.DELAY1_TICKS(D1), .DELAY2_TICKS(D2), .DELAY3_TICKS(D3),
      .DELAY4_TICKS(D4), .DELAY5_TICKS(D5), .DELAY6_TICKS(D6),
      .DOWN_ORDER(rail_seq_pkg::SEQ_321), .TICK_DIVIDE(TD), .SETTLE_TICKS(SET)) uut (
      .clk(clk), .reset(reset), .enable(enable),
      .rail_release_first_in(lvl[0]), .rail_release_first_out(outs[0]),
      .rail_release_first_oe(oe[0]), .rail_release_second_in(lvl[1]),
      .rail_release_second_out(outs[1]), .rail_release_second_oe(oe[1]),
      .rail_release_third_in(lvl[2]), .rail_release_third_out(outs[2]),
      .rail_release_third_oe(oe[2]), .sequence_busy(busy));
   flag_pullups pullups (.oe(oe), .outs(outs), .level(lvl));
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: flags %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int v, input int lo, input int hi);
      compares++;
      if (v < lo || v > hi) begin
         mismatches++;
         $display("wrong value at %0t: delay %0d not in %0d..%0d", $time, v, lo, hi);
      end
   endtask
   task automatic wait_lvl(input int i, input logic v, output int k);
      k = 0;
      while (lvl[i] !== v && k < 3000) begin
         @(negedge clk);
         k++;
      end
   endtask
   task automatic idle();
      repeat (20) @(negedge clk);
   endtask
   task automatic t_reset();
      repeat (4) @(negedge clk);
      chk(lvl, 3'h0);
      reset = 1'b0;
      idle();
      chk({2'h0, busy}, 3'h0);
      chk(lvl, 3'h0);
   endtask
   task automatic t_power_up();
      idle();
      enable = 1'b1;
      wait_lvl(0, 1'b1, n);
      chk_n(n, TD * (D1 + 4), TD * (D1 + 4) + 8);
      chk(lvl, 3'h1);
      chk({2'h0, busy}, 3'h1);
      wait_lvl(1, 1'b1, n);
      chk_n(n, TD * D2 - 2, TD * D2 + 2);
      chk(lvl, 3'h3);
      wait_lvl(2, 1'b1, n);
      chk_n(n, TD * D3 - 2, TD * D3 + 2);
   endtask
   task automatic t_power_down();
      idle();
      enable = 1'b0;
      wait_lvl(2, 1'b0, n);
      chk_n(n, TD * (D4 + 4), TD * (D4 + 4) + 8);
      chk(lvl, 3'h3);
      chk({2'h0, busy}, 3'h1);
      wait_lvl(1, 1'b0, n);
      chk_n(n, TD * D5 - 2, TD * D5 + 2);
      chk(lvl, 3'h1);
      wait_lvl(0, 1'b0, n);
      chk_n(n, TD * D6 - 2, TD * D6 + 2);
   endtask
   task automatic t_glitch_up();
      idle();
      enable = 1'b1;
      repeat (8) @(negedge clk);
      enable = 1'b0;
      repeat (60) @(negedge clk);
      chk(lvl, 3'h0);
      chk({2'h0, busy}, 3'h0);
   endtask
   task automatic t_glitch_down();
      idle();
      enable = 1'b0;
      repeat (8) @(negedge clk);
      enable = 1'b1;
      repeat (60) @(negedge clk);
      chk(lvl, 3'h7);
   endtask
   task automatic t_late_drop();
      idle();
      enable = 1'b1;
      wait_lvl(0, 1'b1, n);
      enable = 1'b0;
      wait_lvl(1, 1'b1, n);
      chk_n(n, 1, 2 * TD * D2 + 4);
      wait_lvl(2, 1'b1, n);
      chk(lvl, 3'h7);
      wait_lvl(2, 1'b0, n);
      chk_n(n, TD * SET, TD * (SET + D4 + 4) + 8);
      wait_lvl(0, 1'b0, n);
      chk(lvl, 3'h0);
   endtask
   task automatic t_late_rise();
      idle();
      enable = 1'b1;
      wait_lvl(2, 1'b1, n);
      idle();
      enable = 1'b0;
      wait_lvl(2, 1'b0, n);
      enable = 1'b1;
      wait_lvl(0, 1'b0, n);
      chk(lvl, 3'h0);
      wait_lvl(0, 1'b1, n);
      chk_n(n, TD * SET, TD * (SET + D1 + 4) + 8);
      wait_lvl(2, 1'b1, n);
      chk(lvl, 3'h7);
   endtask
   task results();
      if (mismatches == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Ceiling well above the several hundred cycles the scenarios need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         mismatches++;
         results();
      end
   end
   initial begin
      t_reset();
      t_glitch_up();
      t_power_up();
      t_glitch_down();
      t_power_down();
      t_late_drop();
      t_late_rise();
      results();
   end
endmodule
bind three_rail_sequencer rail_seq_chk chk_i (.clk, .reset, .rail_release_first_out,
   .rail_release_second_out, .rail_release_third_out, .rail_release_first_oe,
   .rail_release_second_oe, .rail_release_third_oe, .sequence_busy);
`default_nettype wire
